//--- rtl/fbd_ctrl.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// control logic for the five-bit reference converter
module fbd_ctrl
  import fbd_pkg::*;
#(
  parameter int NPIN = 2  // number of reference output pins
) (
  input  wire logic            clk,          // system clock
  input  wire logic            sys_rst,      // synchronous reset, active high
  input  wire logic [3:0]      addr,         // register address
  input  wire logic [7:0]      wdata,        // write data
  input  wire logic            wr,           // write strobe
  input  wire logic            rd,           // read strobe
  output logic      [7:0]      rdata,        // read data, cycle after rd
  input  wire logic [NPIN-1:0] gpio_dout,    // port latch data per pin
  input  wire logic [NPIN-1:0] gpio_oe,      // port driver enable per pin
  input  wire logic [NPIN-1:0] pad_in,       // pad level per pin
  output fbd_pins_t            pins,         // pin controls
  output fbd_level_t           cmp_level,    // comparator positive input
  output fbd_level_t           adc_level,    // ADC input channel
  output fbd_psrc_t            psrc_sel,     // positive source switch
  output logic                 psrc_ok,      // source switch closed
  output logic                 nsrc_gnd,     // negative end to ground
  output logic                 conv_on,      // converter powered
  output logic      [4:0]      level_code    // current level code
);

  fbd_state_t s_q;  // registered state
  fbd_state_t s_d;  // next state
  fbd_level_t lvl_d; // next ladder tap
  // ladder inputs as they will stand after this edge; kept apart from s_d
  // so the tap lookup does not close a loop through the state struct
  logic                  lvl_en;    // next enable
  logic                  lvl_lps;   // next polarity
  logic [FBD_CODE_W-1:0] lvl_code;  // next level code

  // decoded strobes
  logic wr_ctrl;   // write to dac_control_0
  logic wr_level;  // write to level_register
  logic wr_misc;   // write to polarity register

  assign wr_ctrl  = wr && addr == FBD_OFF_CTRL0;
  assign wr_level = wr && addr == FBD_OFF_LEVEL;
  assign wr_misc  = wr && addr == FBD_OFF_MISC;

  // reset needs no term here, the reset branch clears the tap itself
  assign lvl_en   = wr_ctrl  ? wdata[FBD_CTRL_EN_BIT]  : s_q.en;
  assign lvl_lps  = wr_misc  ? wdata[FBD_MISC_LPS_BIT] : s_q.lps;
  assign lvl_code = wr_level ? wdata[FBD_CODE_W-1:0]   : s_q.code;

  // ladder tap from the next register values, so outputs move with them
  fbd_level u_level (
    .en   (lvl_en),
    .lps  (lvl_lps),
    .code (lvl_code),
    .lvl  (lvl_d)
  );

  // next-state logic for registers, read data, and all outputs
  always_comb begin
    s_d = s_q;
    // control register write; unimplemented bits are dropped here
    if (wr_ctrl) begin
      s_d.en  = wdata[FBD_CTRL_EN_BIT];
      s_d.oe  = {wdata[FBD_CTRL_OE2_BIT], wdata[FBD_CTRL_OE1_BIT]};
      s_d.pss = fbd_psrc_t'(wdata[FBD_CTRL_PSS_LO +: 2]);
    end
    // level code write, upper bits ignored
    if (wr_level) begin
      s_d.code = wdata[FBD_CODE_W-1:0];
    end
    // polarity write
    if (wr_misc) begin
      s_d.lps = wdata[FBD_MISC_LPS_BIT];
    end
    // read data valid only the cycle after rd; idle reads as zero
    s_d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        FBD_OFF_CTRL0: begin
          s_d.rdata = {s_q.en, 1'b0, s_q.oe[0], s_q.oe[1], s_q.pss, 2'b00}
                      & FBD_CTRL_MASK;
        end
        FBD_OFF_LEVEL: begin
          s_d.rdata = {3'b000, s_q.code} & FBD_LEVEL_MASK;
        end
        FBD_OFF_MISC: begin
          s_d.rdata = {7'h00, s_q.lps} & FBD_MISC_MASK;
        end
        default: begin
          s_d.rdata = 8'h00;  // unmapped reads return zero
        end
      endcase
    end
    // ladder tap; same value to comparator, ADC and pins
    s_d.lvl = lvl_d;
    // positive source switch; reserved code opens every switch
    s_d.psrc    = s_d.pss;
    s_d.psrc_ok = s_d.pss != FBD_PSRC_RSVD;
    // the negative end has no selection at all
    s_d.nsrc_gnd = 1'b1;
    // pin overrides, one slice per pin
    for (int i = 0; i < NPIN; i++) begin
      s_d.pins.ana_conn[i]  = s_d.oe[i];
      s_d.pins.pad_oe[i]    = gpio_oe[i] && !s_d.oe[i];
      s_d.pins.pad_out[i]   = gpio_dout[i] && !s_d.oe[i];
      s_d.pins.in_det_en[i] = !s_d.oe[i];
      // read back masked while the pin carries the reference level
      s_d.pins.rd_val[i]    = pad_in[i] && !s_d.oe[i];
    end
    // only the device reset clears state; a wake from sleep does not
    if (sys_rst) begin
      s_d = '0;
      s_d.en   = FBD_CTRL_RST[FBD_CTRL_EN_BIT];
      s_d.oe   = 2'b00;
      s_d.pss  = fbd_psrc_t'(FBD_CTRL_RST[FBD_CTRL_PSS_LO +: 2]);
      s_d.code = FBD_LEVEL_RST;
      s_d.lps  = FBD_LPS_RST;
      s_d.lvl  = '0;
      s_d.psrc_ok  = 1'b1;
      s_d.nsrc_gnd = 1'b1;
      s_d.pins.in_det_en = '1;
    end
  end

  // single state register, reset handled in the next-state logic
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // every output straight from the state register
  assign rdata      = s_q.rdata;
  assign pins       = s_q.pins;
  assign cmp_level  = s_q.lvl;
  assign adc_level  = s_q.lvl;
  assign psrc_sel   = s_q.psrc;
  assign psrc_ok    = s_q.psrc_ok;
  assign nsrc_gnd   = s_q.nsrc_gnd;
  assign conv_on    = s_q.en;
  assign level_code = s_q.code;

  // checks on the registered behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // enable follows bit seven one edge after the write
  a_enable_write: assert property (
    wr_ctrl |=> conv_on == $past(wdata[FBD_CTRL_EN_BIT])
  ) else $error("enable did not follow control write");

  // level code write lands next edge, upper bits dropped
  a_code_write: assert property (
    wr_level |=> level_code == $past(wdata[4:0])
  ) else $error("level code did not follow write");

  // enabled tap tracks the code
  a_tap_enabled: assert property (
    conv_on |-> cmp_level.tap == {1'b0, level_code} && cmp_level.driven
  ) else $error("enabled tap differs from code");

  // disabled high end of the ladder
  a_tap_disabled: assert property (
    (!conv_on && s_q.lps && level_code == 5'h1F)
      |-> cmp_level.tap == 6'h20 && cmp_level.driven
  ) else $error("disabled high end not driven");

  // routing of the level to the pins
  a_pin_route: assert property (
    wr_ctrl |=> pins.ana_conn == {$past(wdata[FBD_CTRL_OE2_BIT]), $past(wdata[FBD_CTRL_OE1_BIT])}
  ) else $error("pin routing differs from enables");

  // a routed pin keeps its digital driver and detector off
  a_pin_isolate: assert property (
    (pins.ana_conn & (pins.pad_oe | pins.pad_out | pins.in_det_en)) == '0
  ) else $error("routed pin still digitally active");

  // a routed pin reads back zero even with the pad high
  a_pin_readzero: assert property (
    (pins.ana_conn & pins.rd_val) == '0
  ) else $error("routed pin read not zero");

  // reserved source code opens the source switch
  a_psrc_reserved: assert property (
    s_q.pss == FBD_PSRC_RSVD |-> !psrc_ok
  ) else $error("reserved source selected a switch");

  // unimplemented control bits read zero
  a_ctrl_unimpl: assert property (
    (rd && addr == FBD_OFF_CTRL0) |=> (rdata & ~FBD_CTRL_MASK) == 8'h00
  ) else $error("unimplemented control bits read nonzero");

  // ladder feeds comparator and ADC with one value
  a_level_share: assert property (
    cmp_level == adc_level && nsrc_gnd
  ) else $error("comparator and ADC levels differ");

  // reset leaves the converter off, unrouted, code cleared
  a_reset_clear: assert property (
    @(posedge clk) disable iff (1'b0)
    $past(sys_rst) |-> !conv_on && level_code == 5'h00 && pins.ana_conn == '0
  ) else $error("reset did not clear converter state");

  // main scenarios
  c_enable_route: cover property (wr_ctrl ##1 conv_on && pins.ana_conn[0]);
  c_disabled_top: cover property (!conv_on && cmp_level.tap == 6'h20);
  c_read_level:   cover property (rd && addr == FBD_OFF_LEVEL ##1 rdata != 8'h00);
  c_both_pins:    cover property (pins.ana_conn == 2'b11);

endmodule : fbd_ctrl

//--- rtl/fbd_level.sv
`timescale 1ns/1ps
// ladder tap selection from enable, polarity and code
module fbd_level
  import fbd_pkg::*;
(
  input  wire logic                  en,    // converter enabled
  input  wire logic                  lps,   // disabled polarity
  input  wire logic [FBD_CODE_W-1:0] code,  // level code
  output fbd_level_t                 lvl    // resulting tap
);

  // when enabled, tap is a fraction code/32 of the span above the negative end
  always_comb begin
    lvl.tap    = 6'h00;
    lvl.driven = 1'b0;
    if (en) begin
      lvl.tap    = {1'b0, code};
      lvl.driven = 1'b1;
    end else if (lps && code == FBD_CODE_ONES) begin
      lvl.tap    = FBD_TAP_TOP;
      lvl.driven = 1'b1;
    end else if (!lps && code == FBD_CODE_ZERO) begin
      lvl.tap    = 6'h00;
      lvl.driven = 1'b1;
    end
    // other disabled combinations leave the ladder floating
  end

endmodule : fbd_level

//--- rtl/fbd_pkg.sv
// Function
// - enable bit seven turns converter on
// - thirty-two levels from five-bit level code
// - enabled output: negative plus span times code/32
// - bits five/four route level to pins
// - routed pin loses digital driver and detector
// - routed pin digital read returns zero
// - negative end always tied to ground
// - level feeds comparator, ADC and pins
// - wake from sleep keeps control register
// - reset disables, unroutes, clears level code
package fbd_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] FBD_OFF_CTRL0 = 4'h0;  // dac_control_0
  localparam logic [3:0] FBD_OFF_LEVEL = 4'h1;  // level_register
  localparam logic [3:0] FBD_OFF_MISC  = 4'h2;  // disabled_level_polarity

  // dac_control_0 field positions
  localparam int FBD_CTRL_EN_BIT  = 7;  // conv_enable
  localparam int FBD_CTRL_OE1_BIT = 5;  // ref_out_pin1_enable
  localparam int FBD_CTRL_OE2_BIT = 4;  // ref_out_pin2_enable
  localparam int FBD_CTRL_PSS_LO  = 2;  // positive_source_select low bit
  localparam int FBD_MISC_LPS_BIT = 0;  // disabled_level_polarity

  // writable masks; everything else reads as zero
  localparam logic [7:0] FBD_CTRL_MASK  = 8'hBC;
  localparam logic [7:0] FBD_LEVEL_MASK = 8'h1F;
  localparam logic [7:0] FBD_MISC_MASK  = 8'h01;

  // reset values
  localparam logic [7:0] FBD_CTRL_RST  = 8'h00;
  localparam logic [4:0] FBD_LEVEL_RST = 5'h00;
  localparam logic       FBD_LPS_RST   = 1'b0;

  // level code width and full-scale tap (the positive end of the ladder)
  localparam int         FBD_CODE_W    = 5;
  localparam logic [5:0] FBD_TAP_TOP   = 6'h20;
  localparam logic [4:0] FBD_CODE_ONES = 5'h1F;
  localparam logic [4:0] FBD_CODE_ZERO = 5'h00;

  // positive source choices
  typedef enum logic [1:0] {
    FBD_PSRC_SUPPLY = 2'h0,
    FBD_PSRC_REFPIN = 2'h1,
    FBD_PSRC_FVRBUF = 2'h2,
    FBD_PSRC_RSVD   = 2'h3
  } fbd_psrc_t;

  // analog level towards the ladder switch network
  typedef struct packed {
    logic [5:0] tap;     // level in units of span/32 above negative end
    logic       driven;  // ladder output actually driven
  } fbd_level_t;

  // per-pin group, index 0 is pin1, index 1 is pin2
  typedef struct packed {
    logic [1:0] pad_out;    // digital driver data
    logic [1:0] pad_oe;     // digital driver enable
    logic [1:0] ana_conn;   // analog switch to ladder
    logic [1:0] in_det_en;  // input threshold detector enable
    logic [1:0] rd_val;     // value seen by a digital port read
  } fbd_pins_t;

  // whole block state
  typedef struct packed {
    logic       en;       // conv_enable
    logic [1:0] oe;       // pin routing enables
    fbd_psrc_t  pss;      // positive_source_select
    logic [4:0] code;     // level_code
    logic       lps;      // disabled_level_polarity
    logic [7:0] rdata;    // read data
    fbd_level_t lvl;      // registered level
    fbd_psrc_t  psrc;     // source switch actually closed
    logic       psrc_ok;  // source switch valid
    logic       nsrc_gnd; // negative end to ground
    fbd_pins_t  pins;     // pin controls
  } fbd_state_t;

endpackage : fbd_pkg

//--- tb/fbd_ctrl_bench.sv
`timescale 1ns/1ps
// self-checking bench for the five-bit reference converter control
module fbd_ctrl_bench;
  import fbd_pkg::*;
  logic             clk, sys_rst, wr, rd, rd_d;  // clock, reset, strobes
  logic [3:0]       addr, a;                     // bus address, chosen address
  logic [7:0]       wdata, rdata, d;             // bus data, chosen data
  logic [7:0]       m_ctrl, m_lvl, m_lps;        // register model
  logic [1:0]       gpio_dout, gpio_oe, pad_in;  // port side stimulus
  logic [1:0]       oe;                          // expected routing, bit0 pin1
  fbd_pins_t        pins;                        // pin controls
  fbd_level_t       cmp_level, adc_level, e_lvl; // levels, expected level
  fbd_psrc_t        psrc_sel;                    // positive source switch
  logic             psrc_ok, nsrc_gnd, conv_on;  // status outputs
  logic [4:0]       level_code;                  // level code out
  logic [7:0]       notes[$];                    // expected read data, oldest first
  int               fails, comparisons;          // counters
  integer           seed;                        // random seed

  fbd_ctrl #(.NPIN(2)) uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .gpio_dout(gpio_dout), .gpio_oe(gpio_oe),
    .pad_in(pad_in), .pins(pins), .cmp_level(cmp_level), .adc_level(adc_level),
    .psrc_sel(psrc_sel), .psrc_ok(psrc_ok), .nsrc_gnd(nsrc_gnd), .conv_on(conv_on),
    .level_code(level_code));

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare one value, count and report
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one bus cycle; a read leaves its expected data in the queue
  task bus(input logic w, input logic r, input logic [3:0] ad, input logic [7:0] dd);
    wr    <= w;
    rd    <= r;
    addr  <= ad;
    wdata <= dd;
    if (r) notes.push_back(ad == 4'h0 ? m_ctrl : ad == 4'h1 ? m_lvl : ad == 4'h2 ? m_lps : 8'h00);
    @(posedge clk);
    // model follows the write at the edge that took it
    if (w && ad == 4'h0) m_ctrl = dd & FBD_CTRL_MASK;
    if (w && ad == 4'h1) m_lvl = dd & FBD_LEVEL_MASK;
    if (w && ad == 4'h2) m_lps = dd & FBD_MISC_MASK;
  endtask : bus

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk("rdata", rdata, notes.pop_front());
  end

  // every derived output against the register model, mid-cycle
  task chk_out();
    @(negedge clk);
    oe = {m_ctrl[4], m_ctrl[5]};
    e_lvl = '{tap: 6'h00, driven: 1'b0};
    if (m_ctrl[7]) e_lvl = '{tap: {1'b0, m_lvl[4:0]}, driven: 1'b1};
    else if (m_lps[0] && m_lvl[4:0] == 5'h1F) e_lvl = '{tap: 6'h20, driven: 1'b1};
    else if (!m_lps[0] && m_lvl[4:0] == 5'h00) e_lvl = '{tap: 6'h00, driven: 1'b1};
    chk("conv_on", {7'h00, conv_on}, {7'h00, m_ctrl[7]});
    chk("level_code", {3'h0, level_code}, m_lvl);
    chk("cmp_level", {1'b0, cmp_level}, {1'b0, e_lvl});
    chk("adc_level", {1'b0, adc_level}, {1'b0, e_lvl});
    chk("ana_conn", {6'h00, pins.ana_conn}, {6'h00, oe});
    chk("pad_oe", {6'h00, pins.pad_oe}, {6'h00, gpio_oe & ~oe});
    chk("pad_out", {6'h00, pins.pad_out}, {6'h00, gpio_dout & ~oe});
    chk("in_det_en", {6'h00, pins.in_det_en}, {6'h00, ~oe});
    chk("rd_val", {6'h00, pins.rd_val}, {6'h00, pad_in & ~oe});
    chk("psrc", {5'h00, psrc_ok, psrc_sel}, {5'h00, m_ctrl[3:2] != 2'h3, m_ctrl[3:2]});
    chk("nsrc_gnd", {7'h00, nsrc_gnd}, 8'h01);
    @(posedge clk);
  endtask : chk_out

  // reset for six cycles, then read all registers back
  task reset_check();
    sys_rst <= 1'b1;
    wr      <= 1'b0;  // no strobe stands through the reset
    rd      <= 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    m_ctrl = 8'h00;
    m_lvl  = 8'h00;
    m_lps  = 8'h00;
    bus(1'b0, 1'b1, 4'h0, 8'h00);
    bus(1'b0, 1'b1, 4'h1, 8'h00);
    bus(1'b0, 1'b1, 4'h2, 8'h00);
    bus(1'b0, 1'b0, 4'h0, 8'h00);
    chk_out();
  endtask : reset_check

  // verdict, reached from the main sequence or the watchdog
  task end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // cut a hang short; the run needs well under this
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // main sequence
  initial begin
    seed = 32'h43a354cd;
    fails = 0;
    comparisons = 0;
    {addr, wdata, gpio_dout, gpio_oe, pad_in} = 18'h00000;
    reset_check();
    // random writes, every fourth to the unmapped place, read straight back
    for (int i = 0; i < 60; i++) begin
      a = 4'(i % 4);
      d = 8'($random(seed));
      // pinned values reach both disabled end levels and the reserved source
      case (i)
        8: d = 8'h33;
        9: d = 8'hFF;
        10: d = 8'h01;
        12: d = 8'h4E;
        13, 14: d = 8'h00;
        16: d = 8'hFF;
        default: ;
      endcase
      gpio_dout <= 2'($random(seed));
      gpio_oe   <= 2'($random(seed));
      pad_in    <= 2'($random(seed));
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      chk_out();
    end
    // second reset in mid-run with routing and level set
    bus(1'b1, 1'b0, 4'h0, 8'hB4);
    bus(1'b1, 1'b0, 4'h1, 8'h15);
    reset_check();
    end_of_test();
  end
endmodule : fbd_ctrl_bench
